// [verilog/vxf_device.sv]
// Transform front end: attribute assembly, input buffers, SMT vertex slots, output port.
// Assumes the downstream cache drives outReady only when told to expect data.
`timescale 1ns/1ps
`default_nettype none
module vxf_device #(
    parameter int ATTR_N = vxf_pkg::ATTR_N,
    parameter int BUF_N  = vxf_pkg::BUF_N,
    parameter int SMT_N  = vxf_pkg::SMT_N
) (
    // Clock and reset.
    input  wire logic  clock,
    input  wire logic  reset_n,
    // Status.
    output logic       busy,
    output logic [2:0] buffersUsed,
    // Link.
    vxf_link_if.device link
);
    localparam int PS = ATTR_N;
    localparam int SW = $clog2(ATTR_N + 1);
    localparam int BW = $clog2(BUF_N);

    // The per-buffer down counter is four bits wide, so the processing latency must fit in it.
    if (BUF_N != 6 || SMT_N < 1 || SMT_N > BUF_N || ATTR_N < 1 || ATTR_N > 255
        || vxf_pkg::PROC_CYCLES < 1 || vxf_pkg::PROC_CYCLES > 15) begin : g_bad_params
        $error("vxf_device: unsupported parameters");
    end

    // ==========================================================================
    // Storage
    // ==========================================================================
    logic [127:0] slotQ [0:ATTR_N];
    logic [127:0] ibufQ [0:BUF_N-1][0:ATTR_N-1];
    logic [127:0] tbufQ [0:BUF_N-1];
    logic [BUF_N-1:0] fullQ;
    logic [BUF_N-1:0] doneQ;
    logic [3:0]       cntQ [0:BUF_N-1];
    logic [BW-1:0]    headQ;
    logic [BW-1:0]    tailQ;

    // ==========================================================================
    // Command decode
    // ==========================================================================
    logic [1:0]     word;
    logic [7:0]     vec;
    logic [SW-1:0]  slotSel;
    logic           isW, isR, isT, allFull, anyBusy, outFree, acc;
    logic           readOk;
    logic           emitV;
    logic [127:0]   mergedPass;
    logic [31:0]    rdWord;

    assign word = link.cmdAddr[vxf_pkg::WORD_LSB +: 2];
    assign vec  = 8'(link.cmdAddr[vxf_pkg::ADDR_W-1:vxf_pkg::VEC_LSB]);
    assign slotSel = (link.cmdType == vxf_pkg::CMD_ATTR && vec < 8'(ATTR_N)) ? SW'(vec) : SW'(PS);
    assign isW = link.cmdOp == vxf_pkg::VXF_OP_WRITE;
    assign isR = link.cmdOp == vxf_pkg::VXF_OP_READ;
    assign isT = link.cmdOp == vxf_pkg::VXF_OP_TRIGGER;
    assign allFull = &fullQ;
    assign anyBusy = |fullQ;
    assign busy = anyBusy;
    assign outFree = !link.outValid || link.outReady;

    // Word 0 is the top 32 bits of a vector.
    // The merge starts from the slot being written, so a write keeps the other words, except that an attribute word-0 write resets words 2 and 3.
    always_comb begin
        mergedPass = slotQ[slotSel];
        mergedPass[(3 - word) * 32 +: 32] = link.cmdData[31:0];
        if (link.cmdWide && word < 2'd3) begin
            mergedPass[(2 - word) * 32 +: 32] = link.cmdData[63:32];
        end
    end

    assign readOk = link.cmdType == vxf_pkg::CMD_ATTR && vec < 8'(ATTR_N);
    assign rdWord = slotQ[slotSel][(3 - word) * 32 +: 32];

    always_comb begin
        link.cmdReady = 1'b1;
        if (isT && allFull) begin
            link.cmdReady = 1'b0;
        end
        if (link.cmdType == vxf_pkg::CMD_SYNC && isW && anyBusy) begin
            link.cmdReady = 1'b0;
        end
        // A finished vertex owns the output register first, so an answer in that cycle would be lost.
        if ((isR || (isW && link.cmdType == vxf_pkg::CMD_PASS && word == 2'd3)) && (!outFree || emitV)) begin
            link.cmdReady = 1'b0;
        end
        if (isT && doneQ[tailQ] && fullQ[tailQ] && outFree) begin
            link.cmdReady = 1'b0;
        end
    end
    assign acc = link.cmdValid && link.cmdReady;

    // ==========================================================================
    // Assembly buffer
    // ==========================================================================
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int s = 0; s <= ATTR_N; s++) begin
                slotQ[s] <= 128'h0;
            end
        end else if (acc && isW && link.cmdType != vxf_pkg::CMD_RUN) begin
            slotQ[slotSel] <= mergedPass;
            if (slotSel != SW'(PS) && word == 2'd0) begin
                slotQ[slotSel][63:0] <= {32'h0000_0000, vxf_pkg::ONE_F32};
                slotQ[slotSel][127:64] <= mergedPass[127:64];
            end
        end
    end

    // ==========================================================================
    // Vertex slots and processing
    // ==========================================================================
    // The oldest unfinished vertices get the execution slots, so a full set of
    // buffers can never lock every vertex out of processing.
    logic [BUF_N-1:0] runMask;
    always_comb begin
        int idx;
        int cnt;
        idx = 0;
        cnt = 0;
        runMask = '0;
        for (int k = 0; k < BUF_N; k++) begin
            idx = int'(tailQ) + k;
            if (idx >= BUF_N) begin
                idx = idx - BUF_N;
            end
            if (fullQ[idx] && !doneQ[idx] && cnt < SMT_N) begin
                runMask[idx] = 1'b1;
                cnt = cnt + 1;
            end
        end
    end

    assign emitV = fullQ[tailQ] && doneQ[tailQ] && outFree;

    // The input buffers carry no reset; a buffer is read only after a trigger has filled it.
    always_ff @(posedge clock) begin
        if (acc && isT) begin
            for (int a = 0; a < ATTR_N; a++) begin
                ibufQ[headQ][a] <= slotQ[a];
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fullQ <= '0;
            doneQ <= '0;
            headQ <= '0;
            tailQ <= '0;
            for (int b = 0; b < BUF_N; b++) begin
                cntQ[b] <= 4'd0;
                tbufQ[b] <= 128'h0;
            end
        end else begin
            if (acc && isT) begin
                fullQ[headQ] <= 1'b1;
                doneQ[headQ] <= 1'b0;
                cntQ[headQ]  <= 4'(vxf_pkg::PROC_CYCLES);
                headQ <= (headQ == BW'(BUF_N - 1)) ? '0 : headQ + 1'b1;
            end
            for (int b = 0; b < BUF_N; b++) begin
                if (runMask[b]) begin
                    if (cntQ[b] == 4'd1) begin
                        doneQ[b] <= 1'b1;
                        tbufQ[b] <= {vxf_pkg::vxf_f32_norm(ibufQ[b][0][127:96]),
                                     vxf_pkg::vxf_f32_norm(ibufQ[b][0][95:64]),
                                     vxf_pkg::vxf_f32_norm(ibufQ[b][0][63:32]),
                                     vxf_pkg::vxf_f22_trunc(ibufQ[b][0][31:0])};
                    end
                    cntQ[b] <= cntQ[b] - 4'd1;
                end
            end
            if (emitV) begin
                fullQ[tailQ] <= 1'b0;
                tailQ <= (tailQ == BW'(BUF_N - 1)) ? '0 : tailQ + 1'b1;
            end
        end
    end

    always_comb begin
        buffersUsed = 3'd0;
        for (int b = 0; b < BUF_N; b++) begin
            buffersUsed = buffersUsed + 3'(fullQ[b]);
        end
    end

    // ==========================================================================
    // Output port
    // ==========================================================================
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            link.outValid <= 1'b0;
            link.outKind  <= vxf_pkg::VXF_OUT_VERTEX;
            link.outData  <= 128'h0;
        end else begin
            if (link.outValid && link.outReady) begin
                link.outValid <= 1'b0;
            end
            if (emitV) begin
                link.outValid <= 1'b1;
                link.outKind  <= vxf_pkg::VXF_OUT_VERTEX;
                link.outData  <= tbufQ[tailQ];
            end else if (acc && isR && readOk) begin
                link.outValid <= 1'b1;
                link.outKind  <= vxf_pkg::VXF_OUT_READ;
                link.outData  <= {96'h0, rdWord};
            end else if (acc && isW && link.cmdType == vxf_pkg::CMD_PASS && word == 2'd3) begin
                link.outValid <= 1'b1;
                link.outKind  <= vxf_pkg::VXF_OUT_PASS;
                link.outData  <= mergedPass;
            end
        end
    end
endmodule // vxf_device
`default_nettype wire

// [verilog/vxf_pkg.sv]
// Constants and types shared by both ends of the vertex transform command link.
// Assumes a single pipeline clock and active-low asynchronous reset on every register except the device input buffers.
package vxf_pkg;
    localparam int          ADDR_W       = 12;
    localparam int          ATTR_N       = 16;
    localparam int          BUF_N        = 6;
    localparam int          SMT_N        = 3;
    localparam int          PROC_CYCLES  = 8;
    localparam logic [3:0]  CMD_NOP      = 4'h0;
    localparam logic [3:0]  CMD_ATTR     = 4'h1;
    localparam logic [3:0]  CMD_PARAM    = 4'h4;
    localparam logic [3:0]  CMD_PASS     = 4'h5;
    localparam logic [3:0]  CMD_RUN      = 4'h6;
    localparam logic [3:0]  CMD_CTX      = 4'h9;
    localparam logic [3:0]  CMD_SYNC     = 4'hf;
    localparam logic [31:0] NAN_CANON    = 32'h7fff_ffff;
    localparam logic [31:0] ONE_F32      = 32'h3f80_0000;
    localparam int          F22_CUT      = 10;
    localparam int          WORD_LSB     = 2;
    localparam int          VEC_LSB      = 4;

    typedef enum logic [1:0] {
        VXF_OP_WRITE   = 2'b00,
        VXF_OP_READ    = 2'b01,
        VXF_OP_TRIGGER = 2'b10
    } vxf_op_t;

    typedef enum logic [1:0] {
        VXF_OUT_VERTEX = 2'b00,
        VXF_OUT_PASS   = 2'b01,
        VXF_OUT_READ   = 2'b10
    } vxf_out_t;

    // Flush subnormals to zero and canonicalise NaN.
    function automatic logic [31:0] vxf_f32_norm(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        if (v[30:23] == 8'h00) begin
            r = {v[31], 31'h0000_0000};
        end else if (v[30:23] == 8'hff && v[22:0] != 23'h00_0000) begin
            r = NAN_CANON;
        end
        return r;
    endfunction

    // Reduce to 22-bit lighting precision, keeping the low bits zero.
    function automatic logic [31:0] vxf_f22_trunc(input logic [31:0] v);
        return {v[31:F22_CUT], {F22_CUT{1'b0}}};
    endfunction
endpackage

// [verilog/vxf_link_if.sv]
// Link between the vertex fetch unit and the transform front end.
// Valid/ready handshake on the command input port and vertex output port.
`timescale 1ns/1ps
`default_nettype none
interface vxf_link_if;
    logic                        cmdValid;
    logic                        cmdReady;
    vxf_pkg::vxf_op_t            cmdOp;
    logic [3:0]                  cmdType;
    logic [vxf_pkg::ADDR_W-1:0]  cmdAddr;
    logic                        cmdWide;
    logic [63:0]                 cmdData;
    logic                        outValid;
    logic                        outReady;
    vxf_pkg::vxf_out_t           outKind;
    logic [127:0]                outData;
    modport device (input cmdValid, cmdOp, cmdType, cmdAddr, cmdWide, cmdData, outReady,
                    output cmdReady, outValid, outKind, outData);
    modport host   (output cmdValid, cmdOp, cmdType, cmdAddr, cmdWide, cmdData, outReady,
                    input cmdReady, outValid, outKind, outData);
endinterface
`default_nettype wire

// [verilog/vxf_host.sv]
// Upstream fetch end: turns user requests into link commands, returns output words.
// Assumes the side FIFO toward the cache is outside; outTake is the cache's go-ahead.
`timescale 1ns/1ps
`default_nettype none
module vxf_host (
    // Clock and reset.
    input  wire logic                       clock,
    input  wire logic                       reset_n,
    // User request side.
    input  wire logic                       reqValid,
    output logic                            reqReady,
    input  wire vxf_pkg::vxf_op_t           reqOp,
    input  wire logic [3:0]                 reqType,
    input  wire logic [vxf_pkg::ADDR_W-1:0] reqAddr,
    input  wire logic                       reqWide,
    input  wire logic [63:0]                reqData,
    // Output side, gated by the side FIFO notice.
    input  wire logic                       outTake,
    output logic                            rspValid,
    output vxf_pkg::vxf_out_t               rspKind,
    output logic [127:0]                    rspData,
    // Link.
    vxf_link_if.host                        link
);
    assign reqReady = link.cmdReady;
    assign link.cmdValid = reqValid;
    assign link.cmdOp = reqOp;
    assign link.cmdType = reqType;
    assign link.cmdAddr = {reqAddr[vxf_pkg::ADDR_W-1:2], 2'b00};
    assign link.cmdWide = reqWide & ~reqAddr[2];
    assign link.cmdData = reqData;
    assign link.outReady = outTake;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rspValid <= 1'b0;
            rspKind  <= vxf_pkg::VXF_OUT_VERTEX;
            rspData  <= 128'h0;
        end else begin
            rspValid <= link.outValid & outTake;
            if (link.outValid & outTake) begin
                rspKind <= link.outKind;
                rspData <= link.outData;
            end
        end
    end
endmodule // vxf_host
`default_nettype wire

// [bench/vxf_link_sva.sv]
// Checker for the command link between the fetch end and the transform front end.
// Assumes the bench instantiates it beside the link and feeds it the link's signals.
`timescale 1ns/1ps
`default_nettype none
module vxf_link_sva (
    // Clock and reset.
    input wire logic                       clock,
    input wire logic                       reset_n,
    // Command side.
    input wire logic                       cmdValid,
    input wire logic                       cmdReady,
    input wire vxf_pkg::vxf_op_t           cmdOp,
    input wire logic [3:0]                 cmdType,
    input wire logic [vxf_pkg::ADDR_W-1:0] cmdAddr,
    input wire logic                       cmdWide,
    // Output side.
    input wire logic                       outValid,
    input wire logic                       outReady,
    input wire vxf_pkg::vxf_out_t          outKind,
    input wire logic [127:0]               outData
);
    // ==========
    // Properties.
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_take(op);
        cmdValid && cmdReady && cmdOp == op;
    endsequence
    sequence s_vertex;
        outValid && outKind == vxf_pkg::VXF_OUT_VERTEX;
    endsequence

    a_out_holds: assert property (outValid && !outReady |=> outValid && $stable(outData) && $stable(outKind))
        else $error("output changed before it was taken");
    a_kind_legal: assert property (outValid |-> outKind != 2'b11)
        else $error("output carries an unknown kind");
    a_read_answers: assert property (s_take(vxf_pkg::VXF_OP_READ) ##0 cmdType == 4'h1 && cmdAddr[11:4] < 8'h10
        |=> outValid && outKind == vxf_pkg::VXF_OUT_READ) else $error("readable read gave no answer");
    a_read_drop: assert property (s_take(vxf_pkg::VXF_OP_READ) ##0 cmdType != 4'h1
        |=> !(outValid && outKind == vxf_pkg::VXF_OUT_READ)) else $error("unreadable read was answered");
    a_pass_store: assert property (s_take(vxf_pkg::VXF_OP_WRITE) ##0 cmdType == 4'h5 && cmdAddr[3:2] != 2'd3
        && !cmdWide && !outValid |=> !(outValid && outKind == vxf_pkg::VXF_OUT_PASS)) else $error("partial vector sent");
    a_pass_send: assert property (s_take(vxf_pkg::VXF_OP_WRITE) ##0 cmdType == 4'h5 && cmdAddr[3:2] == 2'd3
        |=> outValid && outKind == vxf_pkg::VXF_OUT_PASS) else $error("completed vector not sent");
    a_trig_emits: assert property (s_take(vxf_pkg::VXF_OP_TRIGGER) |-> ##[8:300] s_vertex)
        else $error("triggered vertex never emitted");
    a_nan_canon: assert property (s_vertex ##0 outData[126:119] == 8'hff && outData[118:96] != 23'h00_0000
        |-> outData[127:96] == 32'h7fff_ffff) else $error("vertex NaN not canonical");
    a_denorm_zero: assert property (s_vertex ##0 outData[94:87] == 8'h00 |-> outData[94:64] == 31'h0000_0000)
        else $error("vertex denormal not flushed");
    a_w_trunc: assert property (s_vertex |-> outData[9:0] == 10'h000)
        else $error("vertex W keeps low mantissa bits");
endmodule // vxf_link_sva
`default_nettype wire

// [bench/vertex_xform_cmd_frontend_bench.sv]
// Bench for both ends of the vertex transform command link, joined by the link interface.
// Assumes the package, link, host, device and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module vertex_xform_cmd_frontend_bench;
    // ==========
    // Signals.
    logic              clock = 1'b0;
    logic              reset_n = 1'b0;
    logic              reqValid = 1'b0;
    logic              reqReady;
    vxf_pkg::vxf_op_t  reqOp = vxf_pkg::VXF_OP_WRITE;
    logic [3:0]        reqType = 4'h0;
    logic [11:0]       reqAddr = 12'h000;
    logic              reqWide = 1'b0;
    logic [63:0]       reqData = 64'h0;
    logic              outTake = 1'b1;
    logic              rspValid;
    vxf_pkg::vxf_out_t rspKind;
    logic [127:0]      rspData;
    logic              busy;
    logic [2:0]        buffersUsed;
    logic [2:0]        maxUsed = 3'h0;
    logic [31:0]       attribute_assembly_buffer [17][4];
    logic [129:0]      expQ [$];
    logic [129:0]      want;
    logic [129:0]      got;
    logic [3:0]        types [4] = '{4'h0, 4'h4, 4'h9, 4'h5};
    int                errTotal = 0;
    int                numChecks = 0;
    const vxf_pkg::vxf_op_t WR = vxf_pkg::VXF_OP_WRITE;
    const vxf_pkg::vxf_op_t RD = vxf_pkg::VXF_OP_READ;

    vxf_link_if link ();
    vxf_host i_vxf_host (.clock(clock), .reset_n(reset_n), .reqValid(reqValid), .reqReady(reqReady),
        .reqOp(reqOp), .reqType(reqType), .reqAddr(reqAddr), .reqWide(reqWide), .reqData(reqData),
        .outTake(outTake), .rspValid(rspValid), .rspKind(rspKind), .rspData(rspData), .link(link));
    vxf_device i_vxf_device (.clock(clock), .reset_n(reset_n), .busy(busy), .buffersUsed(buffersUsed), .link(link));
    vxf_link_sva i_vxf_link_sva (.clock(clock), .reset_n(reset_n), .cmdValid(link.cmdValid),
        .cmdReady(link.cmdReady), .cmdOp(link.cmdOp), .cmdType(link.cmdType), .cmdAddr(link.cmdAddr),
        .cmdWide(link.cmdWide), .outValid(link.outValid), .outReady(link.outReady), .outKind(link.outKind),
        .outData(link.outData));

    always #20 clock = ~clock;

    // ==========
    // Model and checks.
    function automatic logic [31:0] nrm(input logic [31:0] v);
        if (v[30:23] == 8'h00) return {v[31], 31'h0000_0000};
        if (v[30:23] == 8'hff && v[22:0] != 23'h00_0000) return 32'h7fff_ffff;
        return v;
    endfunction

    task automatic check(input logic [129:0] g, input logic [129:0] e);
        numChecks++;
        if (g !== e) begin
            errTotal++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic giveVerdict;
        if (errTotal == 0 && numChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Holds the request up between calls; drain lowers it.
    task automatic send(input vxf_pkg::vxf_op_t op, input logic [3:0] ty, input int vec, input int wd,
                        input logic wide, input logic [63:0] d);
        int n;
        int s;
        n = 0;
        s = (ty == 4'h1) ? vec : 16;
        reqValid <= 1'b1;
        reqOp <= op;
        reqType <= ty;
        reqAddr <= {vec[7:0], wd[1:0], 2'b00};
        reqWide <= wide;
        reqData <= d;
        @(posedge clock);
        while (reqReady !== 1'b1 && n < 500) begin
            n++;
            @(posedge clock);
        end
        check(130'(n < 500), 130'd1);
        if (op == WR && ty != 4'h6) begin
            if (ty == 4'h1 && wd == 0) begin
                attribute_assembly_buffer[s][2] = 32'h0000_0000;
                attribute_assembly_buffer[s][3] = 32'h3f80_0000;
            end
            attribute_assembly_buffer[s][wd] = d[31:0];
            if (wide) attribute_assembly_buffer[s][wd + 1] = d[63:32];
            if (ty == 4'h5 && wd == 3) expQ.push_back({2'b01, attribute_assembly_buffer[16][0], attribute_assembly_buffer[16][1], attribute_assembly_buffer[16][2], attribute_assembly_buffer[16][3]});
        end
        if (op == RD && ty == 4'h1) expQ.push_back({2'b10, 96'h0, attribute_assembly_buffer[s][wd]});
        if (op == vxf_pkg::VXF_OP_TRIGGER)
            expQ.push_back({2'b00, nrm(attribute_assembly_buffer[0][0]), nrm(attribute_assembly_buffer[0][1]), nrm(attribute_assembly_buffer[0][2]), attribute_assembly_buffer[0][3][31:10], 10'h000});
    endtask

    // A dropped read has nothing to wait for, so a few idle cycles expose any stray output.
    task automatic drain;
        int n;
        n = 0;
        reqValid <= 1'b0;
        while ((expQ.size() != 0 || busy !== 1'b0) && n < 2000) begin
            n++;
            @(posedge clock);
        end
        repeat (4) @(posedge clock);
        check(130'(n < 2000), 130'd1);
    endtask

    always @(posedge clock) begin
        outTake <= ($urandom_range(3) != 0);
        if (buffersUsed > maxUsed) maxUsed <= buffersUsed;
        if (link.cmdValid && link.cmdReady && link.cmdType == 4'hf && link.cmdOp == WR)
            check(130'(busy), 130'd0);
        if (rspValid === 1'b1) begin
            want = '1;
            if (expQ.size() != 0) want = expQ.pop_front();
            got = {rspKind, rspData};
            check(got, want);
        end
    end

    // ==========
    // Sequence.
    initial begin
        void'($urandom(32'h67a1_da36));
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        foreach (types[i]) begin
            send(WR, types[i], 0, 0, 1'b1, {$urandom, $urandom});
            send(WR, types[i], 0, 2, 1'b0, 64'($urandom));
            send(WR, types[i], 0, 3, 1'b0, 64'($urandom));
        end
        send(WR, 4'h6, 0, 1, 1'b0, 64'($urandom));
        send(WR, 4'h5, 0, 3, 1'b0, 64'($urandom));
        send(RD, 4'h0, 0, 0, 1'b0, 64'h0);
        send(RD, 4'h5, 1, 3, 1'b0, 64'h0);
        drain;
        send(WR, 4'h1, 0, 0, 1'b1, 64'h0000_0042_7fc0_1234);
        send(WR, 4'h1, 0, 3, 1'b0, 64'($urandom));
        for (int w = 3; w >= 0; w--) send(WR, 4'h1, 5, w, 1'b0, 64'($urandom));
        for (int w = 0; w < 4; w++) send(RD, 4'h1, 5, w, 1'b0, 64'h0);
        send(RD, 4'h1, 0, 1, 1'b0, 64'h0);
        drain;
        repeat (7) send(vxf_pkg::VXF_OP_TRIGGER, 4'h0, 0, 0, 1'b0, 64'h0);
        send(WR, 4'h1, 0, 0, 1'b1, {$urandom, $urandom});
        send(vxf_pkg::VXF_OP_TRIGGER, 4'h0, 0, 0, 1'b0, 64'h0);
        send(WR, 4'hf, 0, 0, 1'b0, 64'h0);
        drain;
        check(130'(maxUsed), 130'd6);
        giveVerdict;
    end

    // The whole sequence needs well under 2000 cycles; this limit leaves ample margin.
    initial begin
        #(40 * 20000);
        errTotal++;
        $display("[FAIL] %0t run did not finish", $time);
        giveVerdict;
    end
endmodule // vertex_xform_cmd_frontend_bench
`default_nettype wire
